/* File: shared/csi_map.svh */
// register offsets, field positions and reset values of the card socket interrupt block
`ifndef CSI_MAP_SVH
`define CSI_MAP_SVH

`define CSI_OFS_CTRL        8'h03
`define CSI_OFS_FLAGS       8'h04
`define CSI_OFS_CFG         8'h05
`define CSI_OFS_GLOBAL      8'h1e

`define CSI_CTRL_RING_BIT   7
`define CSI_CTRL_RESET_BIT  6
`define CSI_CTRL_KIND_BIT   5
`define CSI_CTRL_PCI_BIT    4

`define CSI_CFG_DETECT_BIT  3
`define CSI_CFG_READY_BIT   2
`define CSI_CFG_BATLOW_BIT  1
`define CSI_CFG_BATTERY_DEAD_FLAG_BIT 0

`define CSI_GLOBAL_WR1C_BIT 2

`define CSI_RESET_BYTE      8'h00
`define CSI_ROUTE_SMI       4'h2

`endif

/* File: shared/csi_pkg.sv */
// types of the card socket interrupt block
package csi_pkg;

    typedef struct packed {
        logic       sel;
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } csi_req_t;

    typedef struct packed {
        logic       detect_one_n;
        logic       detect_two_n;
        logic       ready;
        logic       battery_one;
        logic       battery_two;
        logic       status_change_n;
    } csi_card_t;

    typedef struct packed {
        logic [15:0] irq;
        logic        smi;
        logic        pci;
    } csi_route_t;

endpackage

/* File: core/csi_irq_status_control.sv */
// card socket interrupt routing, general control and status-change flags
`timescale 1ns/1ps
`include "csi_map.svh"

module csi_irq_status_control
    import csi_pkg::*;
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       nrst,
    // host register port
    input  wire csi_req_t   req,
    output csi_route_t      func_route,
    output csi_route_t      change_route,
    output logic [7:0]      rdata,
    // card side
    input  wire csi_card_t  card,
    input  wire logic       card_func_irq,
    output logic            card_reset,
    output logic            ring_out
);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // one host target per nonzero code; 0010 is the management line
    function automatic csi_route_t route_of(input logic [3:0] code, input logic active);
        csi_route_t r;
        r = '0;
        if (active && code == `CSI_ROUTE_SMI) begin
            r.smi = 1'b1;
        end else if (active && code != 4'h0) begin
            r.irq[code] = 1'b1;
        end
        return r;
    endfunction

    // write strobe of one register offset
    function automatic logic write_hit(input csi_req_t q, input logic [7:0] offset);
        return q.sel && q.wr && q.addr == offset;
    endfunction

    // read strobe of one offset; a write in the same access wins
    function automatic logic read_hit(input csi_req_t q, input logic [7:0] offset);
        return q.sel && q.rd && !q.wr && q.addr == offset;
    endfunction

    // ------------------------------------------------------------
    // host registers
    // ------------------------------------------------------------
    logic [7:0] ctrl;
    logic [7:0] cfg;
    logic [7:0] glob;
    logic [7:0] next_ctrl;
    logic [7:0] next_cfg;
    logic [7:0] next_glob;

    // config and global are plain storage; only their used bits act
    always_comb begin
        next_ctrl = ctrl;
        next_cfg  = cfg;
        next_glob = glob;
        if (write_hit(req, `CSI_OFS_CTRL)) begin
            next_ctrl = req.wdata;
        end
        if (write_hit(req, `CSI_OFS_CFG)) begin
            next_cfg = req.wdata;
        end
        if (write_hit(req, `CSI_OFS_GLOBAL)) begin
            next_glob = req.wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ctrl <= `CSI_RESET_BYTE;
            cfg  <= `CSI_RESET_BYTE;
            glob <= `CSI_RESET_BYTE;
        end else begin
            ctrl <= next_ctrl;
            cfg  <= next_cfg;
            glob <= next_glob;
        end
    end

    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    logic       io_kind;
    logic       ring_mode;
    logic       to_pci;
    logic [3:0] enables;

    always_comb begin
        io_kind   = ctrl[`CSI_CTRL_KIND_BIT];
        // the shared pin carries ring indicate on an I/O card only
        ring_mode = ctrl[`CSI_CTRL_RING_BIT] && io_kind;
        // a zero functional select forces the PCI route as well
        to_pci    = ctrl[`CSI_CTRL_PCI_BIT] || ctrl[3:0] == 4'h0;
        enables   = {cfg[`CSI_CFG_DETECT_BIT], cfg[`CSI_CFG_READY_BIT],
                     cfg[`CSI_CFG_BATLOW_BIT], cfg[`CSI_CFG_BATTERY_DEAD_FLAG_BIT]};
    end

    // ------------------------------------------------------------
    // card pin history
    // ------------------------------------------------------------
    csi_card_t card_q;
    csi_card_t next_card_q;

    always_comb begin
        next_card_q = card;
    end

    // reset loads the idle levels, so release does not look like an edge
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            card_q <= '1;
        end else begin
            card_q <= next_card_q;
        end
    end

    // ------------------------------------------------------------
    // status-change flags
    // ------------------------------------------------------------
    logic [3:0] flags;
    logic [3:0] next_flags;
    logic [3:0] raw_events;
    logic [3:0] events;
    logic [3:0] clear;

    always_comb begin
        raw_events[3] = (card.detect_one_n != card_q.detect_one_n)
                     || (card.detect_two_n != card_q.detect_two_n);
        raw_events[2] = !io_kind && card.ready && !card_q.ready;
        // warning and dead are levels: the flag returns while they stand
        raw_events[1] = !io_kind && card.battery_one && !card.battery_two;
        if (ring_mode) begin
            raw_events[0] = !card.battery_one && card_q.battery_one;
        end else if (io_kind) begin
            raw_events[0] = !card.status_change_n && card_q.status_change_n;
        end else begin
            raw_events[0] = !card.battery_one;
        end
        events = raw_events & enables;
        // global bit 2 set means write one to clear, otherwise a read clears all
        if (glob[`CSI_GLOBAL_WR1C_BIT]) begin
            clear = write_hit(req, `CSI_OFS_FLAGS) ? req.wdata[3:0] : 4'h0;
        end else begin
            clear = read_hit(req, `CSI_OFS_FLAGS) ? 4'hf : 4'h0;
        end
        // an event in the clearing cycle survives, so no change is lost
        next_flags = ((flags & ~clear) | events) & enables;
        if (io_kind) begin
            next_flags[2:1] = 2'b00;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            flags <= 4'h0;
        end else begin
            flags <= next_flags;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    logic [7:0] next_rdata;
    logic [3:0] shown;

    // read data stands until the next read, so a slow host may fetch it late
    always_comb begin
        shown      = flags & enables;
        next_rdata = rdata;
        if (req.sel && req.rd) begin
            unique case (req.addr)
                `CSI_OFS_CTRL:   next_rdata = ctrl;
                `CSI_OFS_FLAGS:  next_rdata = {4'h0, shown};
                `CSI_OFS_CFG:    next_rdata = cfg;
                `CSI_OFS_GLOBAL: next_rdata = glob;
                default:         next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // routed interrupts and card pins
    // ------------------------------------------------------------
    logic       change_irq;
    csi_route_t next_func_route;
    csi_route_t next_change_route;
    logic       next_card_reset;
    logic       next_ring_out;

    always_comb begin
        // taken from the next flags, so the line moves with the flag edge
        change_irq            = |next_flags;
        next_change_route     = route_of(cfg[7:4], change_irq && !to_pci);
        next_change_route.pci = change_irq && to_pci;
        // functional interrupts exist on I/O cards only
        next_func_route = route_of(ctrl[3:0], card_func_irq && io_kind);
        next_card_reset = !ctrl[`CSI_CTRL_RESET_BIT];
        next_ring_out   = ring_mode && !card.battery_one;
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            func_route   <= '0;
            change_route <= '0;
            card_reset   <= 1'b1;
            ring_out     <= 1'b0;
        end else begin
            func_route   <= next_func_route;
            change_route <= next_change_route;
            card_reset   <= next_card_reset;
            ring_out     <= next_ring_out;
        end
    end

endmodule

/* File: bench/csi_monitor.sv */
// port checks of the card socket interrupt block
`timescale 1ns/1ps
`include "csi_map.svh"
module csi_monitor
    import csi_pkg::*;
(
    // clock and reset
    input wire logic       mclk,
    input wire logic       nrst,
    // host and card side
    input wire csi_req_t   req,
    input wire csi_route_t func_route,
    input wire csi_route_t change_route,
    input wire logic [7:0] rdata,
    input wire logic       card_func_irq,
    input wire logic       card_reset
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    wire rd_flags = req.sel && req.rd && !req.wr && req.addr == `CSI_OFS_FLAGS;
    wire wr_ctrl  = req.sel && req.wr && req.addr == `CSI_OFS_CTRL;
    chk_flags_upper: assert property (rd_flags |=> rdata[7:4] == 4'h0) else $error("upper flags set");
    chk_rdata_stands: assert property (!(req.sel && req.rd) |=> $stable(rdata)) else $error("rdata moved");
    chk_reset_pin: assert property (wr_ctrl |-> ##2 card_reset != $past(req.wdata[6], 2)) else $error("reset pin");
    chk_noroute_zero: assert property (wr_ctrl && req.wdata[3:0] == 4'h0 |-> ##2 func_route == '0) else $error("func on");
    chk_pci_forced: assert property (wr_ctrl && (req.wdata[4] || req.wdata[3:0] == 4'h0)
        |-> ##2 change_route.irq == 16'h0000 && !change_route.smi) else $error("status not pci");
    chk_change_onehot: assert property ($onehot0(change_route)) else $error("two status targets");
    chk_func_cause: assert property (|func_route |-> $past(card_func_irq) || $past(card_func_irq, 2)
        || $past(card_func_irq, 3)) else $error("func route without cause");
    chk_route_holds: assert property ($fell(|change_route) |-> $past(req.sel) || $past(req.sel, 2)
        || $past(req.sel, 3)) else $error("status irq dropped alone");
endmodule
bind csi_irq_status_control csi_monitor mon (.mclk(mclk), .nrst(nrst), .req(req), .func_route(func_route),
    .change_route(change_route), .rdata(rdata), .card_func_irq(card_func_irq), .card_reset(card_reset));

/* File: bench/csi_card_model.sv */
// card in the socket, pins move just after an edge
`timescale 1ns/1ps
module csi_card_model
    import csi_pkg::*;
(
    input  wire logic      mclk,
    input  wire csi_card_t want,
    input  wire logic      want_irq,
    output csi_card_t      card = '1,
    output logic           func_irq = 1'b0
);
    always_ff @(posedge mclk) {card, func_irq} <= {want, want_irq};
endmodule

/* File: bench/tb_top.sv */
// self-checking bench of the card socket interrupt block
`timescale 1ns/1ps
`include "csi_map.svh"
module tb_top
    import csi_pkg::*;
;
    logic       mclk = 0, nrst = 0, wirq = 0, card_func_irq, card_reset, ring_out;
    csi_req_t   req  = '0;
    csi_card_t  want = '1, card;
    csi_route_t func_route, change_route;
    logic [7:0] rdata;
    int         fail_count = 0, n_compared = 0;
    initial forever #4 mclk = ~mclk;
    csi_irq_status_control dut (.mclk(mclk), .nrst(nrst), .req(req), .func_route(func_route),
        .change_route(change_route), .rdata(rdata), .card(card), .card_func_irq(card_func_irq),
        .card_reset(card_reset), .ring_out(ring_out));
    csi_card_model card_mdl (.mclk(mclk), .want(want), .want_irq(wirq), .card(card), .func_irq(card_func_irq));
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t byte got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_route(input csi_route_t got, input csi_route_t exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t route got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_pin(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t pin got %b exp %b", $time, got, exp);
        end
    endtask
    // one access, then room for flags and routes to settle
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        req <= '{1'b1, w, !w, a, d};
        @(posedge mclk);
        req <= '0;
        repeat (3) @(posedge mclk);
        #1;
    endtask
    task automatic rd(input logic [7:0] e);
        acc(1'b0, `CSI_OFS_FLAGS, 8'h00);
        cmp_byte(rdata, e);
    endtask
    // the card model and the flag register each add one edge
    task automatic pins(input logic [5:0] v, input logic irq);
        @(posedge mclk);
        want <= v;
        wirq <= irq;
        repeat (4) @(posedge mclk);
        #1;
    endtask
    task automatic give_verdict;
        if (fail_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        rd(8'h00);
        cmp_pin(card_reset, 1'b1);
        acc(1'b1, `CSI_OFS_CFG, 8'h3f);
        acc(1'b1, `CSI_OFS_CTRL, 8'h41);
        cmp_pin(card_reset, 1'b0);
        pins(6'b010111, 1'b0);
        pins(6'b011111, 1'b0);
        cmp_route(change_route, 18'h0_0020);
        rd(8'h0c);
        cmp_route(change_route, 18'h0_0000);
        rd(8'h00);
        acc(1'b1, `CSI_OFS_GLOBAL, 8'h04);
        acc(1'b1, `CSI_OFS_CTRL, 8'h51);
        pins(6'b011101, 1'b0);
        cmp_route(change_route, 18'h0_0001);
        rd(8'h02);
        pins(6'b011111, 1'b0);
        rd(8'h02);
        acc(1'b1, `CSI_OFS_FLAGS, 8'h02);
        rd(8'h00);
        acc(1'b1, `CSI_OFS_CTRL, 8'h61);
        pins(6'b010101, 1'b0);
        pins(6'b011101, 1'b0);
        rd(8'h00);
        pins(6'b011110, 1'b1);
        rd(8'h01);
        for (int c = 0; c < 16; c++) begin
            acc(1'b1, `CSI_OFS_CTRL, 8'h60 | 8'(c));
            cmp_route(func_route, c == 0 ? 18'h0_0000 : c == 2 ? 18'h0_0002 : 18'h0_0004 << c);
        end
        acc(1'b1, `CSI_OFS_FLAGS, 8'h01);
        acc(1'b1, `CSI_OFS_CTRL, 8'he1);
        pins(6'b011010, 1'b0);
        cmp_pin(ring_out, 1'b1);
        rd(8'h01);
        acc(1'b1, `CSI_OFS_CFG, 8'h37);
        pins(6'b111111, 1'b0);
        rd(8'h01);
        // second reset in mid-run: registers and routes go back to idle
        @(posedge mclk);
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        #1;
        cmp_pin(card_reset, 1'b1);
        cmp_pin(ring_out, 1'b0);
        cmp_route(change_route, 18'h0_0000);
        acc(1'b0, `CSI_OFS_CTRL, 8'h00);
        cmp_byte(rdata, 8'h00);
        pins(6'b011111, 1'b0);
        rd(8'h00);
        acc(1'b1, `CSI_OFS_CFG, 8'h28);
        acc(1'b1, `CSI_OFS_CTRL, 8'h41);
        pins(6'b111111, 1'b0);
        cmp_route(change_route, 18'h0_0002);
        rd(8'h08);
        cmp_route(change_route, 18'h0_0000);
        give_verdict();
    end
endmodule
